// >>> verilog/dlm_map.vh
`ifndef DLM_MAP_VH
`define DLM_MAP_VH
// Register indices (word addresses)
`define DLM_ADDR_TIMING       4'h0
`define DLM_ADDR_SOFT_RESET   4'h1
`define DLM_ADDR_CYCLE_RST    4'h2
`define DLM_ADDR_LINE_SETUP   4'h3
`define DLM_ADDR_CLAMP_CDS    4'h4
`define DLM_ADDR_STATUS       4'h5
// Timing register fields
`define DLM_TIM_SEL_LSB       4
`define DLM_TIM_SINGLE_CHANNEL_MODE_BIT      0
`define DLM_TIM_CHAN_LSB      6
`define DLM_TIM_RESET         8'h10
// Line setup fields
`define DLM_LS_LINE_BIT       0
`define DLM_LS_STEP_BIT       1
`define DLM_LS_MUX_LSB        2
`define DLM_LS_RESET          8'h00
// Clamp / DOUBLE_SAMPLING_ENABLE fields
`define DLM_CC_CDS_BIT        0
`define DLM_CC_CLAMP_BIT      1
`define DLM_CC_RESET          8'h00
// Reset-sample timing codes
`define DLM_TSEL_ADV1         2'h0
`define DLM_TSEL_DEFAULT      2'h1
`define DLM_TSEL_DEL1         2'h2
`define DLM_TSEL_DEL2         2'h3
// Gain set codes
`define DLM_SET_RED           2'h0
`define DLM_SET_GREEN         2'h1
`define DLM_SET_BLUE          2'h2
`define DLM_SET_RSVD          2'h3
// Default reset-sample delay in master clocks
`define DLM_RS_DEFAULT_DLY    3'h2
`endif

// >>> verilog/dlm_pin_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module dlm_pin_sync (
   // Clock and reset
   input  wire i_clk_sys,
   input  wire i_reset_n,
   input  wire i_sync_clear,
   // Pin and result
   input  wire i_pin,
   output reg  o_level,
   output reg  o_rise
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         o_level <= 1'b0;
         o_rise  <= 1'b0;
      end else if (i_sync_clear) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         o_level <= 1'b0;
         o_rise  <= 1'b0;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         o_rise <= 1'b0;
         if (s2_reg == s3_reg) begin
            o_level <= s3_reg;
            o_rise  <= s3_reg & ~o_level;
         end
      end
   end
endmodule // dlm_pin_sync

// >>> verilog/dlm_line_control.v
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "dlm_map.vh"
// Notes on behaviour
// - timing code 00 samples one clock early
// - timing select resets to 01 default
// - channel select ignored unless single-channel
// - any soft reset write resets everything
// - sequence restart write returns to red
// - line mode bit 0, resets 0
// - line mode forces single-channel, channel 00
// - line mode powers down green, blue gain
// - stepping enable only acts in line mode
// - stepping off: pin samples/clamps, mux picks set in line mode
// - stepping on: pin pulse advances set
// - stepping on: clamp follows clamp bit
// - mux 3:2 resets 00; 00 red, 01 green
// - mux 10 blue, 11 reserved
module dlm_line_control (
   // Clock and reset
   input  wire       i_clk_sys,
   input  wire       i_reset_n,
   // Register port
   input  wire [3:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   output reg  [7:0] o_rdata,
   // Timing controller pin
   input  wire       i_reset_sample_pin,
   // Analogue controls
   output reg  [1:0] o_gain_set_sel,
   output reg        o_single_channel_mode,
   output reg  [1:0] o_channel_sel,
   output reg        o_green_gain_pd,
   output reg        o_blue_gain_pd,
   output reg        o_clamp_switch,
   output reg        o_reset_sample_strobe,
   output reg        o_double_sampling_enable
);
   reg  [7:0] timing_reg;
   reg  [7:0] line_reg;
   reg  [7:0] clamp_reg;
   reg  [1:0] step_set_reg;
   reg        soft_rst_reg;
   reg  [4:0] dly_line_reg;
   wire       pin_level;
   wire       pin_rise;

   wire [1:0] tsel      = timing_reg[`DLM_TIM_SEL_LSB +: 2];
   wire       single_channel_mode_bit  = timing_reg[`DLM_TIM_SINGLE_CHANNEL_MODE_BIT];
   wire [1:0] chan_bits = timing_reg[`DLM_TIM_CHAN_LSB +: 2];
   wire       line_mode = line_reg[`DLM_LS_LINE_BIT];
   wire       stepping  = line_mode & line_reg[`DLM_LS_STEP_BIT];
   wire [1:0] mux_sel   = line_reg[`DLM_LS_MUX_LSB +: 2];
   wire       cds_en    = clamp_reg[`DLM_CC_CDS_BIT];
   wire       clamp_bit = clamp_reg[`DLM_CC_CLAMP_BIT];

   // Next set in the red, green, blue cycle; reserved folds back to red
   function [1:0] next_set;
      input [1:0] cur;
      begin
         case (cur)
            `DLM_SET_RED:   next_set = `DLM_SET_GREEN;
            `DLM_SET_GREEN: next_set = `DLM_SET_BLUE;
            default:        next_set = `DLM_SET_RED;
         endcase
      end
   endfunction

   // Pin sync also cleared by soft reset
   dlm_pin_sync u_pin_sync (
      .i_clk_sys    (i_clk_sys),
      .i_reset_n    (i_reset_n),
      .i_sync_clear (soft_rst_reg),
      .i_pin        (i_reset_sample_pin),
      .o_level      (pin_level),
      .o_rise       (pin_rise)
   );

   // Registers; soft reset lands one clock after the write
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         timing_reg   <= `DLM_TIM_RESET;
         line_reg     <= `DLM_LS_RESET;
         clamp_reg    <= `DLM_CC_RESET;
         step_set_reg <= `DLM_SET_RED;
         soft_rst_reg <= 1'b0;
      end else if (soft_rst_reg) begin
         timing_reg   <= `DLM_TIM_RESET;
         line_reg     <= `DLM_LS_RESET;
         clamp_reg    <= `DLM_CC_RESET;
         step_set_reg <= `DLM_SET_RED;
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= i_wr && (i_addr == `DLM_ADDR_SOFT_RESET);
         if (i_wr && i_addr == `DLM_ADDR_TIMING)
            timing_reg <= i_wdata;
         if (i_wr && i_addr == `DLM_ADDR_LINE_SETUP)
            line_reg <= i_wdata & 8'h0F;
         if (i_wr && i_addr == `DLM_ADDR_CLAMP_CDS)
            clamp_reg <= i_wdata & 8'h03;
         // Restart write beats a coincident pulse
         if (i_wr && i_addr == `DLM_ADDR_CYCLE_RST)
            step_set_reg <= `DLM_SET_RED;
         else if (stepping && pin_rise)
            step_set_reg <= next_set(step_set_reg);
      end
   end

   // Read data one cycle after strobe; unmapped reads zero
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `DLM_ADDR_TIMING:     o_rdata <= timing_reg;
            `DLM_ADDR_LINE_SETUP: o_rdata <= line_reg;
            `DLM_ADDR_CLAMP_CDS:  o_rdata <= clamp_reg;
            `DLM_ADDR_STATUS:     o_rdata <= {5'h00, pin_level, step_set_reg};
            default:              o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // Reset-sample instant: delay line tap chosen by timing code
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dly_line_reg <= 5'h00;
      end else if (soft_rst_reg) begin
         dly_line_reg <= 5'h00;
      end else begin
         dly_line_reg <= {dly_line_reg[3:0], pin_rise};
      end
   end

   reg [2:0] tap;
   always @* begin
      case (tsel)
         `DLM_TSEL_ADV1:  tap = `DLM_RS_DEFAULT_DLY - 3'h1;
         `DLM_TSEL_DEL1:  tap = `DLM_RS_DEFAULT_DLY + 3'h1;
         `DLM_TSEL_DEL2:  tap = `DLM_RS_DEFAULT_DLY + 3'h2;
         default:         tap = `DLM_RS_DEFAULT_DLY;
      endcase
   end

   // Output control registers
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_gain_set_sel           <= `DLM_SET_RED;
         o_single_channel_mode    <= 1'b0;
         o_channel_sel            <= 2'h0;
         o_green_gain_pd          <= 1'b0;
         o_blue_gain_pd           <= 1'b0;
         o_clamp_switch           <= 1'b0;
         o_reset_sample_strobe    <= 1'b0;
         o_double_sampling_enable <= 1'b0;
      end else begin
         o_single_channel_mode <= line_mode | single_channel_mode_bit;
         if (line_mode)
            o_channel_sel <= 2'h0;
         else if (single_channel_mode_bit)
            o_channel_sel <= chan_bits;
         else
            o_channel_sel <= 2'h0;
         o_green_gain_pd <= line_mode;
         o_blue_gain_pd  <= line_mode;
         // Set choice: stepping counter or mux field; reserved code holds red
         if (stepping)
            o_gain_set_sel <= step_set_reg;
         else if (line_mode && mux_sel != `DLM_SET_RSVD)
            o_gain_set_sel <= mux_sel;
         else
            o_gain_set_sel <= `DLM_SET_RED;
         // Pin cannot sample or clamp while stepping
         if (stepping) begin
            o_clamp_switch           <= clamp_bit;
            o_reset_sample_strobe    <= 1'b0;
            o_double_sampling_enable <= 1'b0;
         end else begin
            o_clamp_switch           <= ~cds_en & pin_level;
            o_reset_sample_strobe    <= cds_en & dly_line_reg[tap];
            o_double_sampling_enable <= cds_en;
         end
      end
   end
endmodule // dlm_line_control

// >>> dv/dlm_line_control_sva.sv
`timescale 1ns/1ps
module dlm_line_control_sva (
   // Clock, reset, bus
   input wire logic       i_clk_sys,
   input wire logic       i_reset_n,
   input wire logic [3:0] i_addr,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // Controls
   input wire logic [1:0] o_gain_set_sel,
   input wire logic       o_single_channel_mode,
   input wire logic [1:0] o_channel_sel,
   input wire logic       o_green_gain_pd,
   input wire logic       o_blue_gain_pd,
   input wire logic       o_reset_sample_strobe
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   property p_force; o_green_gain_pd |-> o_single_channel_mode && o_channel_sel == 2'h0; endproperty
   a_force: assert property (p_force) else $error("single_channel_mode not forced");
   property p_pd; o_green_gain_pd == o_blue_gain_pd; endproperty
   a_pd: assert property (p_pd) else $error("power-down mismatch");
   property p_gate; !o_green_gain_pd |-> o_gain_set_sel == 2'h0; endproperty
   a_gate: assert property (p_gate) else $error("set moved outside line mode");
   property p_rsvd; o_gain_set_sel != 2'h3; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved set applied");
   property p_soft; i_wr && i_addr == 4'h1 |-> ##4 !o_green_gain_pd && !o_single_channel_mode; endproperty
   a_soft: assert property (p_soft) else $error("soft reset missed");
   property p_restart; i_wr && i_addr == 4'h2 && o_green_gain_pd |-> ##[1:3] o_gain_set_sel == 2'h0; endproperty
   a_restart: assert property (p_restart) else $error("restart missed");
   property p_strobe; o_reset_sample_strobe |=> !o_reset_sample_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe too long");
   property p_rdata; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
   a_rdata: assert property (p_rdata) else $error("read data not idle");
endmodule // dlm_line_control_sva

// >>> dv/dlm_pin_driver.sv
`timescale 1ns/1ps
module dlm_pin_driver (
   input  wire logic i_clk_sys,
   input  wire logic i_go,
   output logic      o_pin
);
   // Four clocks high, then at least three low before a new pulse
   int cnt = 0;
   initial o_pin = 1'b0;
   always @(posedge i_clk_sys) begin
      if (i_go && cnt == 0) cnt <= 6;
      else if (cnt > 0) cnt <= cnt - 1;
      o_pin <= (cnt > 3) || (i_go && cnt == 0);
   end
endmodule // dlm_pin_driver

// >>> dv/dlm_line_control_bench.sv
`timescale 1ns/1ps
`include "dlm_map.vh"
module dlm_line_control_bench;
   logic       i_clk_sys, i_reset_n, i_wr, i_rd, go, pin;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, o_rdata;
   logic [1:0] o_gain_set_sel, o_channel_sel;
   logic       o_single_channel_mode, o_green_gain_pd, o_blue_gain_pd;
   logic       o_clamp_switch, o_reset_sample_strobe, o_double_sampling_enable;
   int         n_fail = 0, cmp_count = 0, cyc = 0, d0, d, c;
   dlm_line_control uut (.i_clk_sys, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_reset_sample_pin(pin), .o_gain_set_sel, .o_single_channel_mode, .o_channel_sel, .o_green_gain_pd,
      .o_blue_gain_pd, .o_clamp_switch, .o_reset_sample_strobe, .o_double_sampling_enable);
   dlm_pin_driver drv (.i_clk_sys, .i_go(go), .o_pin(pin));
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // Ends 1 ns past the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) begin @(posedge i_clk_sys); #1; end
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk_sys); i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
      @(posedge i_clk_sys); i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys); i_addr <= a; i_rd <= 1'b1;
      @(posedge i_clk_sys); i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   task automatic pulse;
      @(posedge i_clk_sys); go <= 1'b1;
      @(posedge i_clk_sys); go <= 1'b0;
   endtask
   task automatic wait_sel(input logic [1:0] exp);
      for (int k = 0; k < 24 && o_gain_set_sel !== exp; k++) tick(1);
      chk(o_gain_set_sel, exp);
   endtask
   task automatic t_regs;
      rd(`DLM_ADDR_TIMING, 8'h10);
      rd(`DLM_ADDR_LINE_SETUP, 8'h00);
      rd(`DLM_ADDR_SOFT_RESET, 8'h00);
      rd(4'hF, 8'h00);
      wr(`DLM_ADDR_LINE_SETUP, 8'hF0);
      rd(`DLM_ADDR_LINE_SETUP, 8'h00);
   endtask
   task automatic t_line;
      wr(`DLM_ADDR_TIMING, 8'hD1);
      tick(3);
      chk(o_single_channel_mode, 1'b1);
      chk(o_channel_sel, 2'h3);
      wr(`DLM_ADDR_LINE_SETUP, 8'h01);
      tick(3);
      chk(o_single_channel_mode, 1'b1);
      chk(o_channel_sel, 2'h0);
      chk({o_green_gain_pd, o_blue_gain_pd}, 2'h3);
      for (c = 0; c < 4; c++) begin
         wr(`DLM_ADDR_LINE_SETUP, 8'(c * 4 + 1));
         tick(3);
         chk(o_gain_set_sel, (c == 3) ? 2'h0 : 2'(c));
      end
   endtask
   task automatic t_step;
      wr(`DLM_ADDR_CLAMP_CDS, 8'h00);
      wr(`DLM_ADDR_LINE_SETUP, 8'h03);
      for (c = 1; c < 5; c++) begin
         pulse;
         wait_sel(2'(c % 3));
         tick(6);
      end
      wr(`DLM_ADDR_CYCLE_RST, 8'hA5);
      tick(3);
      chk(o_gain_set_sel, 2'h0);
      wr(`DLM_ADDR_CLAMP_CDS, 8'h02);
      pulse;
      tick(3);
      chk(o_clamp_switch, 1'b1);
      wr(`DLM_ADDR_CLAMP_CDS, 8'h00);
      pulse;
      tick(3);
      chk(o_clamp_switch, 1'b0);
      // Step bit alone must not move the set
      wr(`DLM_ADDR_LINE_SETUP, 8'h02);
      tick(12);
      pulse;
      tick(16);
      chk(o_gain_set_sel, 2'h0);
   endtask
   task automatic t_timing;
      wr(`DLM_ADDR_CLAMP_CDS, 8'h01);
      for (c = 0; c < 4; c++) begin
         wr(`DLM_ADDR_TIMING, 8'(c << 4));
         tick(4);
         pulse;
         for (d = 0; d < 40 && o_reset_sample_strobe !== 1'b1; d++) tick(1);
         if (c == 0) d0 = d;
         chk(8'(d), 8'(d0 + c));
         tick(8);
      end
      chk(o_double_sampling_enable, 1'b1);
      // Double sampling off: clamp switch follows the pin
      wr(`DLM_ADDR_CLAMP_CDS, 8'h00);
      pulse;
      for (d = 0; d < 24 && o_clamp_switch !== 1'b1; d++) tick(1);
      chk(o_clamp_switch, 1'b1);
      tick(8);
      chk(o_clamp_switch, 1'b0);
   endtask
   task automatic t_soft;
      wr(`DLM_ADDR_LINE_SETUP, 8'h01);
      wr(`DLM_ADDR_SOFT_RESET, 8'h5A);
      tick(5);
      chk(o_green_gain_pd, 1'b0);
      rd(`DLM_ADDR_TIMING, 8'h10);
      rd(`DLM_ADDR_STATUS, 8'h00);
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 20000) begin n_fail++; give_verdict; end
   end
   initial begin
      i_reset_n = 1'b0; i_wr = 1'b0; i_rd = 1'b0; go = 1'b0; i_addr = 4'h0; i_wdata = 8'h00;
      repeat (8) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      wr(`DLM_ADDR_SOFT_RESET, 8'h00);
      tick(3);
      t_regs; t_line; t_step; t_timing; t_soft;
      give_verdict;
   end
endmodule // dlm_line_control_bench
bind dlm_line_control dlm_line_control_sva sva (.i_clk_sys, .i_reset_n, .i_addr, .i_wr, .i_rd, .o_rdata,
   .o_gain_set_sel, .o_single_channel_mode, .o_channel_sel, .o_green_gain_pd, .o_blue_gain_pd,
   .o_reset_sample_strobe);
